// File: hdl/watchdog_consts.vh
// constants for the cascadable watchdog counter block
// assumes one 125 MHz clock; times in their own units, counts derived
`ifndef WATCHDOG_CONSTS_VH
`define WATCHDOG_CONSTS_VH
`define WD_CLK_MHZ         125
`define WD_WIDTH_SMALL     16
`define WD_WIDTH_LARGE     32
`define WD_STRIKE_LIMIT    2'h3
`define WD_TERM_DEFAULT    16'hFFFF
`define WD_PERIOD_MS       2000
// cycles per count step so that a full 16-bit count spans about 2 s
`define WD_PRESCALE_CYCLES ((`WD_PERIOD_MS * 1000 * `WD_CLK_MHZ) / 65536)
`define WD_RESET_PULSE     8'h10
`endif

// File: hdl/cascadable_watchdog.v
// three watchdog counters (16, 16, 32 bit), independent or cascaded
// assumes control inputs synchronous to clock; no software registers
// Contract
// RULE1 - The block holds counters 0 and 1 of 16 bits and counter 2 of 32 bits.
// RULE2 - Each counter either counts on the common tick or on the wrap of the one below it.
// RULE3 - Counter 0 pulses its interrupt each time it reaches its terminal count.
// RULE4 - Three consecutive unserviced counter 0 interrupts issue a system reset.
// RULE5 - With terminal count 0xFFFF counter 0 interrupts come about two seconds apart.
// RULE6 - The watchdog reset restarts the processor from its entry point.
// RULE7 - Software clears counter 0 at least once every six seconds.
// RULE8 - Counter 1 gives an independent periodic tick for the system.
// RULE9 - Clearing counter 0 restarts it at zero and zeroes the strike tally.
`include "watchdog_consts.vh"
`default_nettype none
module cascadable_watchdog #(
  parameter PRESCALE = `WD_PRESCALE_CYCLES
) (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // configuration
  input  wire [2:0]  enable,
  input  wire [2:0]  cascade,
  input  wire [15:0] match0,
  input  wire [15:0] match1,
  input  wire [31:0] match2,
  // service
  input  wire        clear0,
  input  wire        clear1,
  input  wire        clear2,
  input  wire        intAck0,
  // events and counter status
  output reg         irq0,
  output reg         tick1,
  output reg         irq2,
  output reg         systemReset,
  output reg  [1:0]  strikes,
  output reg  [15:0] count0,
  output reg  [15:0] count1,
  output reg  [31:0] count2
);
  // one-hot watchdog states: watching for strikes, or holding the reset line
  localparam [1:0]  ST_WATCH      = 2'b01;
  localparam [1:0]  ST_HOLD       = 2'b10;
  localparam [31:0] PRESCALE_LAST = PRESCALE - 1;

  // a counter steps when enabled, on the common tick or on the event below it
  function stepSel;
    input en;
    input chained;
    input below;
    input common;
    begin
      stepSel = en && (chained ? below : common);
    end
  endfunction

  // a counter ends its period when it steps while sitting on its match value
  function endHit;
    input stepping;
    input atMatch;
    begin
      endHit = stepping && atMatch;
    end
  endfunction

  reg  [31:0] prescale;
  reg  [31:0] next_prescale;
  reg  [7:0]  resetHold;
  reg  [7:0]  next_resetHold;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [1:0]  next_strikes;
  reg         next_systemReset;
  reg  [15:0] next_count0;
  reg  [15:0] next_count1;
  reg  [31:0] next_count2;
  reg         next_irq0;
  reg         next_tick1;
  reg         next_irq2;
  wire        tick;
  wire        step0;
  wire        wrap0;
  wire        strike;
  wire        hit0;
  wire        step1;
  wire        hit1;
  wire        step2;
  wire        hit2;
  wire [1:0]  strikeUp;
  wire        lastStrike;

  // common tick: one count step every PRESCALE clocks
  assign tick       = (prescale == PRESCALE_LAST);
  assign step0      = enable[0] && tick;
  assign wrap0      = endHit(step0, count0 == match0);
  // a wrap cleared in its own cycle counts as serviced, for the chain as well
  assign strike     = wrap0 && !clear0;
  // counter 0 has nothing below it, so cascade[0] is left without effect
  assign hit0       = strike;
  assign step1      = stepSel(enable[1], cascade[1], hit0, tick);
  assign hit1       = endHit(step1, count1 == match1);
  assign step2      = stepSel(enable[2], cascade[2], hit1, tick);
  assign hit2       = endHit(step2, count2 == match2);
  assign strikeUp   = strikes + 2'h1;
  assign lastStrike = strike && (strikeUp == `WD_STRIKE_LIMIT);

  always @* begin
    if (tick) begin
      next_prescale = 32'h0;
    end else begin
      next_prescale = prescale + 32'h1;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prescale <= 32'h0;
    end else begin
      prescale <= next_prescale;
    end
  end

  // counters wrap to zero when they step while on their match value; a clear beats a step
  always @* begin
    next_count0 = count0;
    if (clear0 || wrap0) begin
      next_count0 = 16'h0; // [RULE9]
    end else if (step0) begin
      next_count0 = count0 + 16'h1; // [RULE1] [RULE5]
    end
  end

  always @* begin
    next_count1 = count1;
    if (clear1 || hit1) begin
      next_count1 = 16'h0;
    end else if (step1) begin
      next_count1 = count1 + 16'h1; // [RULE2] [RULE8]
    end
  end

  always @* begin
    next_count2 = count2;
    if (clear2 || hit2) begin
      next_count2 = 32'h0;
    end else if (step2) begin
      next_count2 = count2 + 32'h1; // [RULE1] [RULE2]
    end
  end

  // event pulses last one cycle; a clear in the match cycle swallows the pulse
  always @* begin
    next_irq0  = strike; // [RULE3]
    next_tick1 = hit1 && !clear1; // [RULE8]
    next_irq2  = hit2 && !clear2;
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count0 <= 16'h0;
      count1 <= 16'h0;
      count2 <= 32'h0;
      irq0   <= 1'b0;
      tick1  <= 1'b0;
      irq2   <= 1'b0;
    end else begin
      count0 <= next_count0;
      count1 <= next_count1;
      count2 <= next_count2;
      irq0   <= next_irq0;
      tick1  <= next_tick1;
      irq2   <= next_irq2;
    end
  end

  // strike tally and reset pulse; a new interrupt in an acknowledge cycle
  // still counts, since the acknowledge belongs to the interrupt before it
  always @* begin
    next_state       = state;
    next_resetHold   = resetHold;
    next_strikes     = strikes;
    next_systemReset = 1'b0;
    case (state)
      ST_WATCH: begin
        if (lastStrike) begin
          next_state       = ST_HOLD;
          next_resetHold   = `WD_RESET_PULSE; // [RULE4]
          next_systemReset = 1'b1; // [RULE6]
          next_strikes     = 2'h0;
        end else if (strike) begin
          next_strikes = strikeUp; // [RULE4]
        end else if (clear0 || intAck0) begin
          next_strikes = 2'h0; // [RULE9]
        end
      end
      ST_HOLD: begin
        // the pulse runs its full length; strikes meanwhile are ignored
        next_systemReset = 1'b1; // [RULE6]
        next_strikes     = 2'h0;
        next_resetHold   = resetHold - 8'h1;
        if (resetHold == 8'h01) begin
          next_state = ST_WATCH;
        end
      end
      default: begin
        next_state     = ST_WATCH;
        next_resetHold = 8'h0;
        next_strikes   = 2'h0;
      end
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state       <= ST_WATCH;
      strikes     <= 2'h0;
      systemReset <= 1'b0;
      resetHold   <= 8'h0;
    end else begin
      state       <= next_state;
      strikes     <= next_strikes;
      systemReset <= next_systemReset;
      resetHold   <= next_resetHold;
    end
  end
endmodule
`default_nettype wire

// File: bench/cascadable_watchdog_props.sv
// assertions on counter 0 events and the reset pulse
// assumes binding to the watchdog top, match0 held steady
`default_nettype none
module cascadable_watchdog_props (
  input wire logic        clock, rst, clear0, irq0, systemReset,
  input wire logic [1:0]  strikes,
  input wire logic [15:0] count0, match0
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_hold; systemReset [*8]; endsequence
  property p_irqz; irq0 |-> count0 == 16'h0; endproperty
  a_irqz: assert property (p_irqz) else $error("irq no wrap");
  property p_one; irq0 |=> !irq0; endproperty
  a_one: assert property (p_one) else $error("irq long");
  property p_bnd; count0 <= match0; endproperty
  a_bnd: assert property (p_bnd) else $error("past match");
  property p_step; count0 != $past(count0) |-> count0 == $past(count0) + 16'h1 || count0 == 16'h0;
  endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_fire; $rose(systemReset) |-> irq0 && strikes == 2'h0; endproperty
  a_fire: assert property (p_fire) else $error("bad fire");
  property p_pre; $rose(systemReset) |-> $past(strikes) == 2'h2; endproperty
  a_pre: assert property (p_pre) else $error("early fire");
  property p_len; $rose(systemReset) |-> s_hold; endproperty
  a_len: assert property (p_len) else $error("short reset");
  property p_clr; clear0 |=> count0 == 16'h0 && strikes == 2'h0; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
endmodule
bind cascadable_watchdog cascadable_watchdog_props chk_u (.clock, .rst, .clear0, .irq0,
  .systemReset, .strikes, .count0, .match0);
`default_nettype wire

// File: bench/test_cascadable_watchdog.sv
// bench: strike-out reset, then cleared running with counter 1 ticking
// assumes the design and the bound checker are compiled first
`default_nettype none
module test_cascadable_watchdog;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PRESC = 2, TC0 = 3, TC1 = 2, TC2 = 4;
  logic clock = 0, rst = 1, clear0 = 0, clear1 = 0, intAck0 = 0;
  logic irq0, tick1, irq2, systemReset;
  logic [2:0] enable = 3'h0, cascade = 3'h0;
  logic [1:0] strikes;
  logic [15:0] count0, count1;
  logic [31:0] count2;
  int err_total = 0, cmp_count = 0, n = 0, m = 0;
  always #4 clock = ~clock;
  cascadable_watchdog #(.PRESCALE(PRESC)) dut_u (.clock(clock), .rst(rst), .enable(enable),
    .cascade(cascade), .match0(16'(TC0)), .match1(16'(TC1)), .match2(32'(TC2)),
    .clear0(clear0), .clear1(clear1), .clear2(1'b0), .intAck0(intAck0), .irq0(irq0),
    .tick1(tick1), .irq2(irq2), .systemReset(systemReset), .strikes(strikes),
    .count0(count0), .count1(count1), .count2(count2));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic t_strike();
    enable = 3'h1;
    for (int i = 0; i < 300 && systemReset !== 1'b1; i++) begin
      @(posedge clock); #1;
      n += (irq0 === 1'b1);
    end
    check({15'h0, systemReset}, 16'h1);
    check(16'(n), 16'h3);
    repeat (30) @(posedge clock);
    #1;
  endtask
  task automatic t_clear();
    enable = 3'h3;
    repeat (15) begin
      clear0 = 1;
      @(posedge clock); #1;
      clear0 = 0;
      check(count0, 16'h0);
      repeat (5) begin
        @(posedge clock); #1;
        m |= (tick1 === 1'b1) ? 2 : 0;
        m |= (systemReset !== 1'b0) ? 1 : 0;
      end
    end
    check(16'(m), 16'h2);
  endtask
  // interrupts acknowledged in the cycle they are raised: the tally never climbs past one
  task automatic t_ack();
    int last = -1, gap = 0, top = 0, fired = 0;
    enable = 3'h1;
    for (int i = 0; i < 64; i++) begin
      @(posedge clock); #1;
      intAck0 = irq0;
      if (irq0 === 1'b1) begin
        if (last >= 0) gap = i - last;
        last = i;
      end
      if (strikes > top) top = strikes;
      fired |= (systemReset !== 1'b0);
    end
    check(16'(gap), 16'(PRESC * (TC0 + 1)));
    check(16'(top), 16'h1);
    check(16'(fired), 16'h0);
    @(posedge clock); #1;
    intAck0 = 0;
  endtask
  // counter 1 chained on counter 0 wraps, counter 2 on counter 1 wraps, until counter 2 ends its period
  task automatic t_cascade();
    int wraps = 0, ticks = 0, mid = 0, i = 0;
    enable = 3'h7;
    cascade = 3'h6;
    clear0 = 1;
    clear1 = 1;
    @(posedge clock); #1;
    clear0 = 0;
    clear1 = 0;
    check(count0, 16'h0);
    check(count1, 16'h0);
    while (i < 400 && irq2 !== 1'b1) begin
      @(posedge clock); #1;
      intAck0 = irq0;
      wraps += (irq0 === 1'b1);
      ticks += (tick1 === 1'b1);
      if (tick1 === 1'b1 && ticks == 1) mid = count2;
      i++;
    end
    check({15'h0, irq2}, 16'h1);
    check(16'(wraps), 16'((TC1 + 1) * (TC2 + 1)));
    check(16'(ticks), 16'(TC2 + 1));
    check(16'(mid), 16'h1);
    check(count2[15:0], 16'h0);
    @(posedge clock); #1;
    intAck0 = 0;
  endtask
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    #1 rst = 0;
    t_strike();
    t_clear();
    t_ack();
    t_cascade();
    give_verdict();
  end
endmodule
`default_nettype wire
